// [hdl/mib_defs.vh]
// constants for the statistics counter bank
`ifndef MIB_DEFS_VH
`define MIB_DEFS_VH
`define MIB_REG_TABLE_SEL 8'h79
`define MIB_REG_ADDR_TRIG 8'h7A
`define MIB_REG_DATA3 8'h80
`define MIB_REG_DATA2 8'h81
`define MIB_REG_DATA1 8'h82
`define MIB_REG_DATA0 8'h83
`define MIB_SEL_PORT 8'h1C
`define MIB_SEL_DROP 8'h1D
`define MIB_PORT1_BASE 9'h000
`define MIB_PORT2_BASE 9'h020
`define MIB_PORT3_BASE 9'h040
`define MIB_DROP_BASE 9'h100
`define MIB_PORT_SPAN 32
`define MIB_NUM_PORT_CNT 96
`define MIB_NUM_DROP_CNT 6
`define MIB_OVF_BIT 31
`define MIB_VALID_BIT 30
`define MIB_CNT_W 30
`define MIB_DROP_W 16
`endif

// [hdl/mib_counters.v]
// statistics counter bank with indirect read window
`timescale 1ns/1ns
// Summary of operation
// R1: thirty-two counters kept per switch port
// R2: word holds overflow, valid, thirty-bit count
// R3: host rereads from top byte if invalid
// R4: ports based at 0x00, 0x20, 0x40
// R5: offsets 0-1 count receive octets by priority
// R6: offsets 2-4 count short, fragment, long frames
// R7: offsets 5-6 count long-bad, bad-symbol frames
// R8: offsets 7-8 count checksum, misaligned frames
// R9: offsets 9-A count control and pause frames
// R10: offsets B-D count broadcast, multicast, unicast
// R11: offsets E-13 bin frames by length
// R12: offsets 14-15 count transmit octets by priority
// R13: offset 16 counts late collisions
// R14: offsets 17-1A count transmit pause and casts
// R15: offsets 1B-1F count deferrals and collisions
// R16: drop word holds sixteen-bit count
// R17: offsets 100-105 count resource drops
// R18: host selects table then writes trigger
// R19: word shown top byte first in 80-83
// R20: per-port counter clears when read
// R21: drop counters keep value, no flags
// R22: host reads all counters every thirty seconds
// R23: select bit zero forms address bit eight
// R24: overflow sticks until read-clear
`include "mib_defs.vh"
module mib_counters
(
  CLK,
  RSTN,
  REG_ADDR,
  REG_WDATA,
  REG_WR,
  REG_RD,
  REG_RDATA,
  PORT_EVT,
  PORT_INC,
  DROP_EVT
);
  input wire CLK;
  input wire RSTN;
  input wire [7:0] REG_ADDR;
  input wire [7:0] REG_WDATA;
  input wire REG_WR;
  input wire REG_RD;
  output reg [7:0] REG_RDATA;
  // one bit per counter, index = port*32 + offset
  input wire [95:0] PORT_EVT;
  // amount added on an event, octet counters use lengths
  input wire [287:0] PORT_INC;
  input wire [5:0] DROP_EVT;

  // ------------------------------------------------------------
  // counter offsets within one port
  // ------------------------------------------------------------
  localparam [4:0] rx_low_prio_octets = 5'h00;
  localparam [4:0] rx_high_prio_octets = 5'h01;
  localparam [4:0] rx_short_frames = 5'h02;
  localparam [4:0] rx_fragment_frames = 5'h03;
  localparam [4:0] rx_long_good_frames = 5'h04;
  localparam [4:0] rx_long_bad_frames = 5'h05;
  localparam [4:0] rx_bad_symbol_frames = 5'h06;
  localparam [4:0] rx_checksum_fail_frames = 5'h07;
  localparam [4:0] rx_misaligned_frames = 5'h08;
  localparam [4:0] rx_mac_control_frames = 5'h09;
  localparam [4:0] rx_pause_frames = 5'h0A;
  localparam [4:0] rx_bcast_frames = 5'h0B;
  localparam [4:0] rx_mcast_frames = 5'h0C;
  localparam [4:0] rx_ucast_frames = 5'h0D;
  localparam [4:0] rx_len_64 = 5'h0E;
  localparam [4:0] rx_len_65_127 = 5'h0F;
  localparam [4:0] rx_len_128_255 = 5'h10;
  localparam [4:0] rx_len_256_511 = 5'h11;
  localparam [4:0] rx_len_512_1023 = 5'h12;
  localparam [4:0] rx_len_1024_max = 5'h13;

  localparam [4:0] tx_low_prio_octets = 5'h14;
  localparam [4:0] tx_high_prio_octets = 5'h15;
  localparam [4:0] tx_late_collisions = 5'h16;
  localparam [4:0] tx_pause_frames = 5'h17;
  localparam [4:0] tx_bcast_frames = 5'h18;
  localparam [4:0] tx_mcast_frames = 5'h19;
  localparam [4:0] tx_ucast_frames = 5'h1A;
  localparam [4:0] tx_deferred_frames = 5'h1B;
  localparam [4:0] tx_all_collisions = 5'h1C;
  localparam [4:0] tx_collision_aborts = 5'h1D;
  localparam [4:0] tx_one_collision_frames = 5'h1E;
  localparam [4:0] tx_many_collision_frames = 5'h1F;

  // drop counter addresses, shared by all ports
  localparam [8:0] drop_tx_port1 = 9'h100;
  localparam [8:0] drop_tx_port2 = 9'h101;
  localparam [8:0] drop_tx_port3 = 9'h102;
  localparam [8:0] drop_rx_port1 = 9'h103;
  localparam [8:0] drop_rx_port2 = 9'h104;
  localparam [8:0] drop_rx_port3 = 9'h105;

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  reg [29:0] cnt_q [0:95];
  reg [95:0] ovf_q;
  reg [95:0] vld_q;
  reg [15:0] drop_q [0:5];
  reg [7:0] sel_q;
  reg [7:0] trig_q;
  reg [31:0] word_q;
  reg [7:0] rdata_d;
  reg [31:0] word_d;
  wire [8:0] addr_w;
  wire trig_w;
  wire trig_port_w;
  wire [6:0] trig_idx_w;
  reg [95:0] clr_d;
  integer i;
  integer j;
  integer k;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  assign addr_w = {sel_q[0], trig_q}; // R23
  assign trig_w = REG_WR && (REG_ADDR == `MIB_REG_ADDR_TRIG); // R18
  assign trig_port_w = trig_w && is_port_addr(sel_q, {sel_q[0], REG_WDATA}); // R4
  assign trig_idx_w = REG_WDATA[6:0];

  function [29:0] inc_of;
    input [287:0] v;
    input [6:0] n;
    begin
      inc_of = {27'h0, v[n*3 +: 3]};
    end
  endfunction

  // one clear strobe per counter, decoded once for the count and flag processes
  always @*
  begin
    clr_d = 96'h0;
    for (k = 0; k < `MIB_NUM_PORT_CNT; k = k + 1)
      if (trig_port_w && (trig_idx_w == k[6:0]))
        clr_d[k] = 1'b1; // R20
  end

  function is_port_addr;
    input [7:0] sel;
    input [8:0] a;
    begin
      is_port_addr = (sel == `MIB_SEL_PORT) && (a < `MIB_PORT3_BASE + 9'h020); // R4
    end
  endfunction

  function is_drop_addr;
    input [7:0] sel;
    input [8:0] a;
    begin
      is_drop_addr = (sel == `MIB_SEL_DROP) && (a >= `MIB_DROP_BASE) &&
        (a < `MIB_DROP_BASE + 9'h006); // R17
    end
  endfunction

  // ------------------------------------------------------------
  // window registers
  // ------------------------------------------------------------
  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      sel_q <= 8'h00;
      trig_q <= 8'h00;
    end
    else if (REG_WR)
    begin
      if (REG_ADDR == `MIB_REG_TABLE_SEL)
        sel_q <= REG_WDATA;
      if (REG_ADDR == `MIB_REG_ADDR_TRIG)
        trig_q <= REG_WDATA;
    end
  end

  // snapshot uses the incoming trigger byte so the read reflects this write
  always @*
  begin
    word_d = word_q;
    if (trig_w)
    begin
      if (is_port_addr(sel_q, {sel_q[0], REG_WDATA}))
        word_d = {ovf_q[REG_WDATA[6:0]], vld_q[REG_WDATA[6:0]],
          cnt_q[REG_WDATA[6:0]]}; // R2 R19
      else if (is_drop_addr(sel_q, {sel_q[0], REG_WDATA}))
        word_d = {16'h0000, drop_q[REG_WDATA[2:0]]}; // R16 R19 R21
      else
        word_d = 32'h00000000;
    end
  end

  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      word_q <= 32'h00000000;
    else
      word_q <= word_d;
  end

  // ------------------------------------------------------------
  // per-port counters
  // ------------------------------------------------------------
  // a read-clear in the same cycle as an event keeps that event: it seeds the count
  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      for (i = 0; i < `MIB_NUM_PORT_CNT; i = i + 1)
        cnt_q[i] <= 30'h00000000;
    end
    else
    begin
      for (i = 0; i < `MIB_NUM_PORT_CNT; i = i + 1)
      begin
        if (clr_d[i])
          cnt_q[i] <= PORT_EVT[i] ? inc_of(PORT_INC, i[6:0]) : 30'h00000000; // R20
        // R1 R5 R6 R7 R8 R9 R10 R11 R12 R13 R14 R15
        else if (PORT_EVT[i])
          cnt_q[i] <= cnt_q[i] + inc_of(PORT_INC, i[6:0]);
      end
    end
  end

  // the flag sticks through later counting so the host learns of a wrap it missed
  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      ovf_q <= 96'h0;
    else
    begin
      for (j = 0; j < `MIB_NUM_PORT_CNT; j = j + 1)
      begin
        if (clr_d[j])
          ovf_q[j] <= 1'b0; // R24
        else if (PORT_EVT[j] && (cnt_q[j] > 30'h3FFFFFFF - inc_of(PORT_INC, j[6:0])))
          ovf_q[j] <= 1'b1; // R24
      end
    end
  end

  // the snapshot is taken in one edge, so valid is withheld only until the first edge after reset
  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      vld_q <= 96'h0;
    else
      vld_q <= {96{1'b1}}; // R2
  end

  // ------------------------------------------------------------
  // drop counters
  // ------------------------------------------------------------
  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      for (i = 0; i < `MIB_NUM_DROP_CNT; i = i + 1)
        drop_q[i] <= 16'h0000;
    end
    else
    begin
      for (i = 0; i < `MIB_NUM_DROP_CNT; i = i + 1)
        if (DROP_EVT[i])
          drop_q[i] <= drop_q[i] + 16'h0001; // R17 R21
    end
  end

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  always @*
  begin
    case (REG_ADDR)
      `MIB_REG_TABLE_SEL: rdata_d = sel_q;
      `MIB_REG_ADDR_TRIG: rdata_d = trig_q;
      `MIB_REG_DATA3: rdata_d = word_q[31:24]; // R19
      `MIB_REG_DATA2: rdata_d = word_q[23:16];
      `MIB_REG_DATA1: rdata_d = word_q[15:8];
      `MIB_REG_DATA0: rdata_d = word_q[7:0];
      default: rdata_d = 8'h00;
    endcase
  end

  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      REG_RDATA <= 8'h00;
    else if (REG_RD)
      REG_RDATA <= rdata_d;
  end
endmodule // mib_counters

// [verif/mib_chk.sv]
// checker for the counter window
`timescale 1ns/1ns
module mib_chk
(
  input wire CLK,
  input wire RSTN,
  input wire [7:0] REG_ADDR,
  input wire [7:0] REG_WDATA,
  input wire REG_WR,
  input wire REG_RD,
  input wire [7:0] REG_RDATA
);
  reg [7:0] s_q;
  reg [7:0] t_q;
  reg [1:0] k_q;
  wire dr = REG_RD && REG_ADDR[7:2] == 6'h20;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // snapshot kind follows the select seen at trigger time
  always @(posedge CLK or negedge RSTN)
    if (!RSTN)
      {s_q, t_q, k_q} <= 18'h00000;
    else if (REG_WR && REG_ADDR == 8'h79)
      s_q <= REG_WDATA;
    else if (REG_WR && REG_ADDR == 8'h7A)
      {t_q, k_q} <= {REG_WDATA, s_q == 8'h1D && REG_WDATA < 8'h06,
        s_q == 8'h1C && REG_WDATA < 8'h60};
  property p_hold; !REG_RD |=> $stable(REG_RDATA); endproperty
  a_hold: assert property (p_hold) else $error("rdata moved");
  property p_low; REG_RD && REG_ADDR < 8'h79 |=> REG_RDATA == 8'h00; endproperty
  a_low: assert property (p_low) else $error("low read");
  property p_high; REG_RD && REG_ADDR > 8'h83 |=> REG_RDATA == 8'h00; endproperty
  a_high: assert property (p_high) else $error("high read");
  property p_sel; REG_RD && REG_ADDR == 8'h79 |=> REG_RDATA == $past(s_q); endproperty
  a_sel: assert property (p_sel) else $error("select");
  property p_trg; REG_RD && REG_ADDR == 8'h7A |=> REG_RDATA == $past(t_q); endproperty
  a_trg: assert property (p_trg) else $error("trigger");
  property p_vld; k_q[0] && dr && REG_ADDR[1:0] == 2'h0 |=> REG_RDATA[6]; endproperty
  a_vld: assert property (p_vld) else $error("valid");
  property p_drp; k_q[1] && dr && !REG_ADDR[1] |=> REG_RDATA == 8'h00; endproperty
  a_drp: assert property (p_drp) else $error("drop top");
  property p_bad; k_q == 2'h0 && dr |=> REG_RDATA == 8'h00; endproperty
  a_bad: assert property (p_bad) else $error("bad select");
endmodule // mib_chk
bind mib_counters mib_chk mib_chk_inst (.CLK(CLK), .RSTN(RSTN), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA));

// [verif/mib_host.sv]
// host model for the register window
`timescale 1ns/1ns
module mib_host
(
  input wire clk,
  input wire [7:0] rdata,
  output reg [7:0] addr,
  output reg [7:0] wdata,
  output reg wr,
  output reg rd
);
  initial {addr, wdata, wr, rd} = 18'h00000;
  // released lines flip so stale values never look valid
  task wr8(input [7:0] a, input [7:0] d);
  begin
    @(negedge clk);
    {addr, wdata, wr} = {a, d, 1'b1};
    @(negedge clk);
    {addr, wdata, wr} = {~a, ~d, 1'b0};
  end
  endtask
  task rd8(input [7:0] a, output [7:0] d);
  begin
    @(negedge clk);
    {addr, rd} = {a, 1'b1};
    @(negedge clk);
    {addr, rd, d} = {~a, 1'b0, rdata};
  end
  endtask
endmodule // mib_host

// [verif/tb.sv]
// bench for the counter bank
`timescale 1ns/1ns
module tb;
  reg CLK = 1'b0;
  reg RSTN = 1'b0;
  reg [95:0] PORT_EVT = 96'h0;
  reg [287:0] PORT_INC = 288'h0;
  reg [5:0] DROP_EVT = 6'h0;
  wire [7:0] REG_ADDR, REG_WDATA, REG_RDATA;
  wire REG_WR, REG_RD;
  integer n_errors = 0;
  integer n_compared = 0;
  integer i;
  reg [31:0] w, ex;
  reg [7:0] b;
  reg [23:0] rows [0:4];
  always #50 CLK = ~CLK;
  mib_counters mib_counters_inst (.CLK(CLK), .RSTN(RSTN), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .PORT_EVT(PORT_EVT), .PORT_INC(PORT_INC), .DROP_EVT(DROP_EVT));
  mib_host mib_host_inst (.clk(CLK), .rdata(REG_RDATA), .addr(REG_ADDR),
    .wdata(REG_WDATA), .wr(REG_WR), .rd(REG_RD));
  task chk(input [31:0] e, input [31:0] g);
  begin
    n_compared = n_compared + 1;
    if (g !== e)
    begin
      n_errors = n_errors + 1;
      $display("FAIL word expected %h seen %h", e, g);
    end
  end
  endtask
  task rdw(input [7:0] s, input [7:0] t);
    integer k;
  begin
    mib_host_inst.wr8(8'h79, s);
    mib_host_inst.wr8(8'h7A, t);
    for (k = 0; k < 4; k = k + 1)
    begin
      mib_host_inst.rd8({6'h20, k[1:0]}, b);
      w = {w[23:0], b};
      if (k == 0 && s == 8'h1C && t < 8'h60 && !b[6])
        k = -1;
    end
  end
  endtask
  task results;
  begin
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask
  initial
  begin
    // select, trigger, pulses, increment
    rows[0] = {8'h1C, 8'h00, 5'h09, 3'h7};
    rows[1] = {8'h1C, 8'h2E, 5'h03, 3'h1};
    rows[2] = {8'h1C, 8'h5F, 5'h1F, 3'h1};
    rows[3] = {8'h1D, 8'h00, 5'h04, 3'h1};
    rows[4] = {8'h1D, 8'h05, 5'h02, 3'h1};
    repeat (4) @(negedge CLK);
    RSTN = 1'b1;
    mib_host_inst.rd8(8'h79, b);
    chk(32'h0, {24'h0, b});
    for (i = 0; i < 5; i = i + 1)
    begin
      @(negedge CLK);
      PORT_INC = {96{rows[i][2:0]}};
      if (rows[i][16])
        DROP_EVT[rows[i][10:8]] = 1'b1;
      else
        PORT_EVT[rows[i][14:8]] = 1'b1;
      repeat (rows[i][7:3]) @(negedge CLK);
      {PORT_EVT, DROP_EVT} = 102'h0;
      ex = rows[i][7:3] * rows[i][2:0];
      rdw(rows[i][23:16], rows[i][15:8]);
      chk(ex | {1'b0, !rows[i][16], 30'h0}, w);
      rdw(rows[i][23:16], rows[i][15:8]);
      chk(rows[i][16] ? ex : 32'h40000000, w);
    end
    mib_host_inst.wr8(8'h83, 8'hA5);
    mib_host_inst.rd8(8'h83, b);
    chk({24'h0, w[7:0]}, {24'h0, b});
    rdw(8'h18, 8'h00);
    chk(32'h0, w);
    mib_host_inst.rd8(8'h7A, b);
    chk(32'h0, {24'h0, b});
    mib_host_inst.rd8(8'h10, b);
    chk(32'h0, {24'h0, b});
    mib_host_inst.rd8(8'hFF, b);
    chk(32'h0, {24'h0, b});
    // an event on the read-clear edge seeds the fresh count
    mib_host_inst.wr8(8'h79, 8'h1C);
    PORT_INC = {96{3'h5}};
    PORT_EVT[1] = 1'b1;
    mib_host_inst.wr8(8'h7A, 8'h01);
    PORT_EVT[1] = 1'b0;
    rdw(8'h1C, 8'h01);
    chk(32'h40000005, w);
    // reset in mid-run clears a count that has just moved
    PORT_EVT[2] = 1'b1;
    @(negedge CLK);
    PORT_EVT[2] = 1'b0;
    RSTN = 1'b0;
    @(negedge CLK);
    RSTN = 1'b1;
    rdw(8'h1C, 8'h02);
    chk(32'h40000000, w);
    results;
  end
  // the sequence needs well under a thousand cycles
  initial
  begin
    #200000;
    n_errors = n_errors + 1;
    results;
  end
endmodule // tb
